// ==== ssw_top.sv ====
// Module: core and I/O rail supervisor control with wake-up execution mask
// Functional notes
// - After soft clear, event flags stay dead if supervisor was disabled before it.
// - Any control register write after soft clear revives event flags.
// - Normal-mode core comparators hold CPU 150 us after sleep three/four wake.
// - Both core comparators off or full performance: mask only 2 us.
// - Peripheral clock from tunable oscillator is not masked on deep wake.
// - Full-performance core supervisor settling delay is about 2 us.
// - Raising core level in full performance lets delay expire early, resets.
// - Core supervisor state follows enable, perf, keep and auto-control table.
// - Core monitor state follows enable, perf and auto-control table.
// - Wake from sleep two to four slow if core comparator in normal mode.
// - Normal-mode I/O comparator turns off in sleep if keep clear or auto.
// - Fast wake plus I/O comparator off: interrupt within 1 us may hang.
// - Soft power-up clear also clears the failed-wake condition.
// - Supervisor event sets its flag and optionally requests power-on reset.
`timescale 1ns/10ps
module ssw_top #(
   parameter int SLOW_CYCLES = ssw_pkg::SLOW_CYC,
   parameter int FAST_CYCLES = ssw_pkg::FAST_CYC
) (
   // Clock and reset
   input  wire logic              sys_clk,
   input  wire logic              resetn,
   // APB slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic      [31:0]       prdata,
   output logic                   pready,
   output logic                   pslverr,
   // Power and system events
   input  wire logic              soft_power_up_clear,
   input  wire logic              sleep_enter,
   input  wire logic              wake_irq,
   input  wire logic              core_level_raise,
   input  wire ssw_pkg::ssw_trip_s trip,
   // Outputs
   output logic                   cpu_hold,
   output logic                   por_request,
   output logic                   osc_unmasked
);

   // ************************************************************
   // Elaboration checks
   // ************************************************************
   if (SLOW_CYCLES < 1 || SLOW_CYCLES >= (1 << ssw_pkg::CNT_W) ||
       FAST_CYCLES < 1 || FAST_CYCLES > SLOW_CYCLES) begin : g_bad_param
      $error("ssw_top: bad delay parameters");
   end

   // ************************************************************
   // Registers and internal signals
   // ************************************************************
   ssw_pkg::ssw_ctl_s     core_ctl;
   ssw_pkg::ssw_ctl_s     io_ctl;
   logic [ssw_pkg::FLG_W-1:0] flags;
   logic [1:0]            sleep_level;   // 2, 3 or 4 coded as 0..2
   logic [2:0]            cpu_clock_divider;
   logic                  flag_dead;
   logic                  prev_disabled;
   ssw_pkg::ssw_pwr_e     pwr;
   ssw_pkg::ssw_pwr_e     next_pwr;
   ssw_pkg::ssw_cmp_e     core_sup_st;
   ssw_pkg::ssw_cmp_e     core_mon_st;
   ssw_pkg::ssw_cmp_e     io_sup_st;
   ssw_pkg::ssw_cmp_e     io_mon_st;
   logic                  core_dly_busy;
   logic                  io_dly_busy;
   logic                  wake_busy;
   logic [ssw_pkg::CNT_W-1:0] core_dly_cyc;
   logic [ssw_pkg::CNT_W-1:0] wake_cyc;
   logic [ssw_pkg::CNT_W-1:0] hz_cnt;
   logic                  wr_en;
   logic                  rd_en;
   logic                  core_wr;
   logic                  io_wr;
   logic                  asleep;
   logic                  fast_wake;
   logic                  io_drop;
   logic                  core_evt;
   logic                  io_evt;
   logic                  wake_start;

   // ************************************************************
   // APB decode: zero wait states, error on unmapped address
   // ************************************************************
   assign wr_en   = psel && penable && pwrite;
   assign rd_en   = psel && !penable && !pwrite;
   assign core_wr = wr_en && (paddr == ssw_pkg::CORE_CTL_ADDR);
   assign io_wr   = wr_en && (paddr == ssw_pkg::IO_CTL_ADDR);

   // Ready: asserted in every access phase
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable &&
                    paddr != ssw_pkg::CORE_CTL_ADDR &&
                    paddr != ssw_pkg::IO_CTL_ADDR &&
                    paddr != ssw_pkg::FLAG_ADDR &&
                    paddr != ssw_pkg::MODE_ADDR &&
                    paddr != ssw_pkg::STATE_ADDR;
      end
   end

   // Read data captured in setup phase
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h00000000;
      end else if (rd_en) begin
         unique case (paddr)
            ssw_pkg::CORE_CTL_ADDR: prdata <= {25'h0, core_ctl};
            ssw_pkg::IO_CTL_ADDR:   prdata <= {25'h0, io_ctl};
            ssw_pkg::FLAG_ADDR:     prdata <= {26'h0, flags};
            ssw_pkg::MODE_ADDR:     prdata <= {27'h0, cpu_clock_divider,
                                               sleep_level};
            ssw_pkg::STATE_ADDR:    prdata <= {22'h0, pwr, io_mon_st,
                                               io_sup_st, core_mon_st,
                                               core_sup_st};
            default:                prdata <= 32'h00000000;
         endcase
      end
   end

   // Control registers; soft clear returns them to reset value
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         core_ctl <= ssw_pkg::CTL_RESET;
         io_ctl   <= ssw_pkg::CTL_RESET;
      end else if (soft_power_up_clear) begin
         core_ctl <= ssw_pkg::CTL_RESET;
         io_ctl   <= ssw_pkg::CTL_RESET;
      end else begin
         if (core_wr)
            core_ctl <= pwdata[ssw_pkg::CTL_W-1:0];
         if (io_wr)
            io_ctl <= pwdata[ssw_pkg::CTL_W-1:0];
      end
   end

   // Mode register: sleep level and cpu divider field
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         sleep_level       <= 2'h1;
         cpu_clock_divider <= 3'h0;
      end else if (wr_en && paddr == ssw_pkg::MODE_ADDR) begin
         sleep_level       <= pwdata[1:0];
         cpu_clock_divider <= pwdata[4:2];
      end
   end

   // ************************************************************
   // Flag kill after soft clear with supervisor disabled
   // ************************************************************
   assign prev_disabled = !core_ctl.sup_en || !io_ctl.sup_en;

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         flag_dead <= 1'b0;
      else if (soft_power_up_clear)
         flag_dead <= prev_disabled;
      else if (core_wr || io_wr)
         flag_dead <= 1'b0;
   end

   // ************************************************************
   // Comparator states per table
   // ************************************************************
   assign asleep = (pwr == ssw_pkg::SSW_SLEEP) || (pwr == ssw_pkg::SSW_STUCK);

   function automatic ssw_pkg::ssw_cmp_e perf(input logic en,
                                               input logic fp);
      if (!en)
         return ssw_pkg::SSW_CMP_OFF;
      return fp ? ssw_pkg::SSW_CMP_FULL : ssw_pkg::SSW_CMP_NORM;
   endfunction

   // Supervisor: off in sleep unless kept; auto makes kept full -> normal
   function automatic ssw_pkg::ssw_cmp_e sup_state(input ssw_pkg::ssw_ctl_s c,
                                                    input logic slp);
      if (!slp || !c.sup_en)
         return perf(c.sup_en, c.sup_fp);
      if (!c.sup_keep)
         return ssw_pkg::SSW_CMP_OFF;
      if (!c.auto_ctl)
         return perf(1'b1, c.sup_fp);
      return c.sup_fp ? ssw_pkg::SSW_CMP_NORM : ssw_pkg::SSW_CMP_OFF;
   endfunction

   // Monitor: unchanged under manual; auto steps one level down
   function automatic ssw_pkg::ssw_cmp_e mon_state(input ssw_pkg::ssw_ctl_s c,
                                                    input logic slp);
      if (!slp || !c.auto_ctl || !c.mon_en)
         return perf(c.mon_en, c.mon_fp);
      return c.mon_fp ? ssw_pkg::SSW_CMP_NORM : ssw_pkg::SSW_CMP_OFF;
   endfunction

   // Registered comparator states
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         core_sup_st <= ssw_pkg::SSW_CMP_NORM;
         core_mon_st <= ssw_pkg::SSW_CMP_OFF;
         io_sup_st   <= ssw_pkg::SSW_CMP_NORM;
         io_mon_st   <= ssw_pkg::SSW_CMP_OFF;
      end else begin
         core_sup_st <= sup_state(core_ctl, asleep);
         core_mon_st <= mon_state(core_ctl, asleep);
         io_sup_st   <= sup_state(io_ctl, asleep);
         io_mon_st   <= mon_state(io_ctl, asleep);
      end
   end

   // ************************************************************
   // Wake speed and hazard condition
   // ************************************************************
   assign fast_wake = !((core_ctl.sup_en && !core_ctl.sup_fp) ||
                        (core_ctl.mon_en && !core_ctl.mon_fp));
   assign io_drop   = (io_ctl.sup_en && !io_ctl.sup_fp &&
                       (!io_ctl.sup_keep || io_ctl.auto_ctl)) ||
                      (io_ctl.mon_en && !io_ctl.mon_fp &&
                       io_ctl.auto_ctl);

   // Core settling delay: full performance about 2 us, normal about 150 us; I/O side always about 150 us
   assign core_dly_cyc = core_ctl.sup_fp ?
                         ssw_pkg::CNT_W'(FAST_CYCLES) :
                         ssw_pkg::CNT_W'(SLOW_CYCLES);
   assign wake_cyc     = fast_wake ? ssw_pkg::CNT_W'(FAST_CYCLES) :
                         ssw_pkg::CNT_W'(SLOW_CYCLES);

   assign wake_start = (pwr == ssw_pkg::SSW_SLEEP) && wake_irq;

   // Power sequencing state
   always_comb begin
      next_pwr = pwr;
      unique case (pwr)
         ssw_pkg::SSW_ACTIVE:
            if (sleep_enter)
               next_pwr = ssw_pkg::SSW_SLEEP;
         ssw_pkg::SSW_SLEEP:
            if (wake_irq && fast_wake && io_drop &&
                hz_cnt < ssw_pkg::CNT_W'(ssw_pkg::HAZARD_CYC))
               next_pwr = ssw_pkg::SSW_STUCK;
            else if (wake_irq)
               next_pwr = ssw_pkg::SSW_WAKE;
         ssw_pkg::SSW_WAKE:
            if (!wake_busy)
               next_pwr = ssw_pkg::SSW_ACTIVE;
         ssw_pkg::SSW_STUCK:
            next_pwr = ssw_pkg::SSW_STUCK;
      endcase
   end

   // State register; soft clear frees a failed wake
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         pwr <= ssw_pkg::SSW_ACTIVE;
      else if (soft_power_up_clear)
         pwr <= ssw_pkg::SSW_ACTIVE;
      else
         pwr <= next_pwr;
   end

   // Cycles since sleep entry, saturating
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         hz_cnt <= '0;
      else if (pwr != ssw_pkg::SSW_SLEEP)
         hz_cnt <= '0;
      else if (hz_cnt != {ssw_pkg::CNT_W{1'b1}})
         hz_cnt <= hz_cnt + 1'b1;
   end

   // ************************************************************
   // Delay counters
   // ************************************************************
   ssw_delay #(.CW(ssw_pkg::CNT_W)) u_core_dly (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .start   (core_wr || core_level_raise),
      .cycles  (core_dly_cyc),
      .busy    (core_dly_busy)
   );

   ssw_delay #(.CW(ssw_pkg::CNT_W)) u_io_dly (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .start   (io_wr),
      .cycles  (ssw_pkg::CNT_W'(SLOW_CYCLES)),
      .busy    (io_dly_busy)
   );

   ssw_delay #(.CW(ssw_pkg::CNT_W)) u_wake (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .start   (wake_start),
      .cycles  (wake_cyc),
      .busy    (wake_busy)
   );

   // ************************************************************
   // Flags: supervisor events masked during settling; set wins over clear
   // ************************************************************
   assign core_evt = !flag_dead && !core_dly_busy &&
                     ((trip.core_sup && core_sup_st != ssw_pkg::SSW_CMP_OFF) ||
                      (core_level_raise && core_ctl.sup_fp));
   assign io_evt   = !flag_dead && !io_dly_busy && trip.io_sup &&
                     io_sup_st != ssw_pkg::SSW_CMP_OFF;

   for (genvar i = 0; i < ssw_pkg::FLG_W; i++) begin : g_flag
      logic set_i;
      always_comb begin
         unique case (i)
            ssw_pkg::FLG_CORE_DLY: set_i = core_wr;
            ssw_pkg::FLG_IO_DLY:   set_i = io_wr;
            ssw_pkg::FLG_CORE_EVT: set_i = core_evt;
            ssw_pkg::FLG_IO_EVT:   set_i = io_evt;
            ssw_pkg::FLG_CORE_MON: set_i = !flag_dead &&
                                   trip.core_mon &&
                                   core_mon_st != ssw_pkg::SSW_CMP_OFF;
            default:               set_i = !flag_dead &&
                                   trip.io_mon &&
                                   io_mon_st != ssw_pkg::SSW_CMP_OFF;
         endcase
      end
      always_ff @(posedge sys_clk or negedge resetn) begin
         if (!resetn)
            flags[i] <= 1'b0;
         else if (set_i)
            flags[i] <= 1'b1;
         else if (i == ssw_pkg::FLG_CORE_DLY)
            flags[i] <= flags[i] && core_dly_busy;
         else if (i == ssw_pkg::FLG_IO_DLY)
            flags[i] <= flags[i] && io_dly_busy;
         else if (wr_en && paddr == ssw_pkg::FLAG_ADDR && pwdata[i])
            flags[i] <= 1'b0;
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         cpu_hold     <= 1'b0;
         por_request  <= 1'b0;
         osc_unmasked <= 1'b0;
      end else begin
         cpu_hold     <= (next_pwr != ssw_pkg::SSW_ACTIVE);
         // A held trip still gives separate one-cycle requests
         por_request  <= !por_request &&
                         ((core_evt && core_ctl.rst_en) ||
                          (io_evt && io_ctl.rst_en));
         osc_unmasked <= (pwr == ssw_pkg::SSW_WAKE) &&
                         (sleep_level != 2'h0);
      end
   end

endmodule

// ==== ssw_pkg.sv ====
// Package: register map, field layout, states and timing of the supervisor block
package ssw_pkg;

   // ************************************************************
   // Register map (byte addresses)
   // ************************************************************
   localparam logic [7:0] CORE_CTL_ADDR  = 8'h00;
   localparam logic [7:0] IO_CTL_ADDR    = 8'h04;
   localparam logic [7:0] FLAG_ADDR      = 8'h08;
   localparam logic [7:0] MODE_ADDR      = 8'h0C;
   localparam logic [7:0] STATE_ADDR     = 8'h10;

   // ************************************************************
   // Control field positions (both control registers alike)
   // ************************************************************
   localparam int SUP_EN_BIT    = 0;
   localparam int SUP_KEEP_BIT  = 1;
   localparam int SUP_FP_BIT    = 2;
   localparam int MON_EN_BIT    = 3;
   localparam int MON_FP_BIT    = 4;
   localparam int AUTO_BIT      = 5;
   localparam int RST_EN_BIT    = 6;
   localparam int CTL_W         = 7;
   // Supervisor enabled, normal mode, reset enable set
   localparam logic [6:0] CTL_RESET = 7'h49;

   // Flag register fields
   localparam int FLG_CORE_DLY  = 0;
   localparam int FLG_IO_DLY    = 1;
   localparam int FLG_CORE_EVT  = 2;
   localparam int FLG_IO_EVT    = 3;
   localparam int FLG_CORE_MON  = 4;
   localparam int FLG_IO_MON    = 5;
   localparam int FLG_W         = 6;

   // Mode register: sleep level request, cpu divider field
   localparam logic [2:0] DIV_BY_TWO = 3'h1;

   // ************************************************************
   // Timing at 25 MHz
   // ************************************************************
   localparam int CLK_MHZ        = 25;
   localparam int SLOW_US        = 150;
   localparam int FAST_US        = 2;
   localparam int HAZARD_US      = 1;
   localparam int SLOW_CYC       = SLOW_US * CLK_MHZ;
   localparam int FAST_CYC       = FAST_US * CLK_MHZ;
   localparam int HAZARD_CYC     = HAZARD_US * CLK_MHZ;
   localparam int CNT_W          = 13;

   // ************************************************************
   // Comparator state and power mode encodings
   // ************************************************************
   typedef enum logic [1:0] {
      SSW_CMP_OFF  = 2'b00,
      SSW_CMP_NORM = 2'b01,
      SSW_CMP_FULL = 2'b10
   } ssw_cmp_e;

   typedef enum logic [1:0] {
      SSW_ACTIVE = 2'b00,
      SSW_SLEEP  = 2'b01,
      SSW_WAKE   = 2'b10,
      SSW_STUCK  = 2'b11
   } ssw_pwr_e;

   // Control register content
   typedef struct packed {
      logic rst_en;
      logic auto_ctl;
      logic mon_fp;
      logic mon_en;
      logic sup_fp;
      logic sup_keep;
      logic sup_en;
   } ssw_ctl_s;

   // Supply comparator trip inputs
   typedef struct packed {
      logic core_sup;
      logic core_mon;
      logic io_sup;
      logic io_mon;
   } ssw_trip_s;

endpackage

// ==== ssw_delay.sv ====
// Module: delay counter for the settling time of one supervisor side or for the wake mask
`timescale 1ns/10ps
module ssw_delay #(
   parameter int CW = 13
) (
   // Clock and reset
   input  wire logic          sys_clk,
   input  wire logic          resetn,
   // Control
   input  wire logic          start,
   input  wire logic [CW-1:0] cycles,
   // Status
   output logic               busy
);

   logic [CW-1:0] count;

   // Load on start, count down to zero, busy while counting
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         count <= '0;
         busy  <= 1'b0;
      end else if (start) begin
         count <= cycles;
         busy  <= 1'b1;
      end else if (count > 1) begin
         count <= count - 1'b1;
      end else begin
         count <= '0;
         busy  <= 1'b0;
      end
   end

endmodule

// ==== ssw_properties.sv ====
// Checker: port-level timing properties of the supervisor block
`timescale 1ns/10ps
module ssw_properties #(
   parameter int SLOW_CYCLES = ssw_pkg::SLOW_CYC,
   parameter int FAST_CYCLES = ssw_pkg::FAST_CYC
) (
   // Clock and reset
   input wire logic        sys_clk,
   input wire logic        resetn,
   // APB side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Power side
   input wire logic        sleep_enter,
   input wire logic        cpu_hold,
   input wire logic        por_request,
   input wire logic        osc_unmasked
);
   // ************************************************************
   // Helper logic
   // ************************************************************
   int osc_cnt;
   // Current unmasked stretch counted, cleared when the mask returns
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) osc_cnt <= 0;
      else if (osc_unmasked) osc_cnt <= osc_cnt + 1;
      else osc_cnt <= 0;
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   // ************************************************************
   // Properties
   // ************************************************************
   a_ready_after_setup: assert property (s_setup |=> pready)
      else $error("pready missing after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held too long");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("pready outside access phase");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_unmapped_zero: assert property (pready && pslverr && !pwrite
      |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_por_single_pulse: assert property (por_request |=> !por_request)
      else $error("reset request longer than one cycle");
   a_sleep_holds_cpu: assert property (sleep_enter |-> ##[1:2] cpu_hold)
      else $error("cpu not held in sleep");
   a_mask_bounded: assert property (osc_cnt <= SLOW_CYCLES + 4)
      else $error("wake mask longer than slow length");
endmodule
bind ssw_top ssw_properties #(
   .SLOW_CYCLES(SLOW_CYCLES),
   .FAST_CYCLES(FAST_CYCLES)
) u_props (
   .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .sleep_enter(sleep_enter), .cpu_hold(cpu_hold),
   .por_request(por_request), .osc_unmasked(osc_unmasked)
);

// ==== ssw_top_tb_top.sv ====
// Testbench: register, sleep, wake and event checks of the supervisor block
`timescale 1ns/10ps
module ssw_top_tb_top;
   localparam int SLW = 20;
   localparam int FST = 4;
   logic        sys_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        pready, pslverr, er, cpu_hold, por_request, osc_unmasked;
   logic        soft_power_up_clear = 0, sleep_enter = 0, wake_irq = 0;
   logic        core_level_raise = 0, osc_seen;
   ssw_pkg::ssw_trip_s trip = '0;
   int          failures = 0, num_checks = 0, por_cnt = 0, n, e;
   ssw_top #(.SLOW_CYCLES(SLW), .FAST_CYCLES(FST)) DUT (
      .sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr),
      .soft_power_up_clear(soft_power_up_clear), .sleep_enter(sleep_enter),
      .wake_irq(wake_irq), .core_level_raise(core_level_raise),
      .trip(trip), .cpu_hold(cpu_hold), .por_request(por_request),
      .osc_unmasked(osc_unmasked));
   // Clock and pulse bookkeeping
   always #20 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      if (por_request === 1'b1) por_cnt++;
      if (osc_unmasked === 1'b1) osc_seen = 1;
   end
   // ************************************************************
   // Tasks
   // ************************************************************
   task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s exp %h got %h", nm, exp, got);
      end
   endtask
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      rd = prdata; er = pslverr;
      psel <= 0; penable <= 0;
   endtask
   task automatic cyc(int c);
      repeat (c) @(posedge sys_clk);
   endtask
   // One-cycle pulse: 0 sleep, 1 wake, 2 level raise, 3 soft clear
   task automatic pulse(int w);
      @(posedge sys_clk);
      case (w)
         0: sleep_enter <= 1;
         1: wake_irq <= 1;
         2: core_level_raise <= 1;
         default: soft_power_up_clear <= 1;
      endcase
      @(posedge sys_clk);
      case (w)
         0: sleep_enter <= 0;
         1: wake_irq <= 0;
         2: core_level_raise <= 0;
         default: soft_power_up_clear <= 0;
      endcase
   endtask
   task automatic trip_core;
      @(posedge sys_clk); trip.core_sup <= 1;
      @(posedge sys_clk); trip.core_sup <= 0;
      cyc(4);
   endtask
   // Comparator states {mon, sup} for a core control word
   function automatic logic [3:0] st(logic [6:0] c, logic s);
      logic [1:0] sp, mn;
      sp = !c[0] ? 2'h0 : !s ? (c[2] ? 2'h2 : 2'h1) : c[5] ?
           {1'b0, c[1] & c[2]} : (c[1] ? (c[2] ? 2'h2 : 2'h1) : 2'h0);
      mn = !c[3] ? 2'h0 : (!s || !c[5]) ? (c[4] ? 2'h2 : 2'h1) :
           {1'b0, c[4]};
      return {mn, sp};
   endfunction
   task automatic print_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ************************************************************
   // Sequence
   // ************************************************************
   initial begin
      cyc(16);
      resetn <= 1;
      apb(0, ssw_pkg::CORE_CTL_ADDR, 0); chk("core", rd, 32'h49);
      apb(0, ssw_pkg::IO_CTL_ADDR, 0); chk("io", rd, 32'h49);
      apb(0, ssw_pkg::STATE_ADDR, 0); chk("state", rd, 32'h55);
      apb(0, 8'h14, 0); chk("unmapped", {er, rd[30:0]}, 32'h80000000);
      apb(1, ssw_pkg::IO_CTL_ADDR, 32'h49);
      apb(1, ssw_pkg::CORE_CTL_ADDR, 32'h49);
      apb(0, ssw_pkg::FLAG_ADDR, 0); chk("dly set", rd & 3, 3);
      cyc(2 * SLW + 10);
      apb(0, ssw_pkg::FLAG_ADDR, 0); chk("dly clr", rd & 3, 0);
      apb(1, ssw_pkg::MODE_ADDR, 32'h05);
      apb(0, ssw_pkg::MODE_ADDR, 0); chk("mode", rd, 32'h05);
      // Every core control combination with reset enable clear through sleep and wake
      for (int c = 0; c < 64; c++) begin
         apb(1, ssw_pkg::CORE_CTL_ADDR, c);
         cyc(SLW + 10);
         apb(0, ssw_pkg::STATE_ADDR, 0);
         chk("act", rd, {28'h005, st(c, 0)});
         pulse(0);
         cyc(30);
         apb(0, ssw_pkg::STATE_ADDR, 0);
         chk("slp", rd, {28'h014, st(c, 1)});
         osc_seen = 0;
         e = ((c[0] & !c[2]) | (c[3] & !c[4])) ? SLW : FST;
         @(posedge sys_clk); wake_irq <= 1;
         n = 0;
         do begin
            @(posedge sys_clk);
            n++;
         end while (cpu_hold !== 1'b0 && n < 200);
         wake_irq <= 0;
         chk("mask", n >= e && n <= e + 4, 1);
         chk("osc", osc_seen, 1);
      end
      // Divider back to zero only after the settle wait
      cyc(100);
      apb(1, ssw_pkg::MODE_ADDR, 32'h01);
      apb(0, ssw_pkg::MODE_ADDR, 0); chk("div", rd, 32'h01);
      apb(1, ssw_pkg::CORE_CTL_ADDR, 32'h49);
      cyc(30);
      trip_core;
      apb(0, ssw_pkg::FLAG_ADDR, 0); chk("evt", rd[2], 1);
      chk("por", por_cnt, 1);
      apb(1, ssw_pkg::FLAG_ADDR, 32'h3C);
      apb(0, ssw_pkg::FLAG_ADDR, 0); chk("w1c", rd[2], 0);
      apb(1, ssw_pkg::CORE_CTL_ADDR, 32'h45);
      cyc(30);
      pulse(2);
      cyc(5);
      chk("raise", por_cnt, 2);
      // Raise in normal mode: no reset request
      apb(1, ssw_pkg::CORE_CTL_ADDR, 32'h49);
      cyc(30);
      pulse(2);
      cyc(5);
      chk("raise norm", por_cnt, 2);
      apb(1, ssw_pkg::FLAG_ADDR, 32'h3C);
      // Fast wake with io drop hangs until soft clear
      apb(1, ssw_pkg::CORE_CTL_ADDR, 0);
      cyc(30);
      pulse(0);
      cyc(3);
      pulse(1);
      cyc(60);
      chk("stuck", cpu_hold, 1);
      pulse(3);
      cyc(3);
      chk("unstuck", cpu_hold, 0);
      apb(0, ssw_pkg::CORE_CTL_ADDR, 0); chk("puc", rd, 32'h49);
      cyc(30);
      trip_core;
      apb(0, ssw_pkg::FLAG_ADDR, 0); chk("dead", rd[2], 0);
      apb(1, ssw_pkg::CORE_CTL_ADDR, 32'h09);
      cyc(30);
      trip_core;
      apb(0, ssw_pkg::FLAG_ADDR, 0); chk("revive", rd[2], 1);
      // Io side kept on in sleep: early wake does not hang
      apb(1, ssw_pkg::IO_CTL_ADDR, 32'h4B);
      apb(1, ssw_pkg::CORE_CTL_ADDR, 0);
      cyc(30);
      pulse(0);
      cyc(3);
      pulse(1);
      cyc(20);
      chk("kept", cpu_hold, 0);
      print_verdict;
   end
   // Watchdog against a hang
   initial begin
      cyc(60000);
      failures++;
      print_verdict;
   end
endmodule
